// ==== rtl/cfg_port_pkg.sv ====
// shared constants and types for the serial configuration port
package cfg_port_pkg;

  // frame layout, most significant bit first
  localparam int CMD_BITS  = 8;
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 16;

  // command codes
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_READ  = 8'h03;

  // two-wire slave address: fixed upper bits
  localparam logic [2:0] I2C_ADDR_HIGH = 3'h6;

  // timing
  localparam int CLK_MHZ        = 125;
  localparam int GAP_US         = 125;
  localparam int GAP_CYCLES_DEF = GAP_US * CLK_MHZ;
  localparam int SCLK_HALF_DEF  = 8;
  localparam int SS_EDGE_HALVES = 3;

  // reset values
  localparam logic [7:0]  ADDR_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic [1:0] {
    FR_CMD  = 2'b00,
    FR_ADDR = 2'b01,
    FR_DATA = 2'b10,
    FR_SKIP = 2'b11
  } frame_state_t;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_LEAD  = 3'b001,
    HS_SHIFT = 3'b010,
    HS_TRAIL = 3'b011,
    HS_GAP   = 3'b100
  } host_state_t;

endpackage

// ==== rtl/spi_link_if.sv ====
// four-wire serial link between the host master and the device slave
`timescale 1ns/10ps
`default_nettype none
interface spi_link_if;
  logic sclk;
  logic ss_b;
  logic mosi;
  logic miso_out;
  logic miso_oe;
  logic miso;

  // line driven low when the slave releases it
  assign miso = miso_oe ? miso_out : 1'b0;

  modport dev (
    input  sclk,
    input  ss_b,
    input  mosi,
    output miso_out,
    output miso_oe
  );

  modport host (
    output sclk,
    output ss_b,
    output mosi,
    input  miso
  );
endinterface
`default_nettype wire

// ==== rtl/cfg_port_dev.sv ====
// device end: serial slave with frame decode and slave address selection
`timescale 1ns/10ps
`default_nettype none
module cfg_port_dev
  import cfg_port_pkg::*;
#(
  parameter int GAP_CYCLES = cfg_port_pkg::GAP_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  // serial link
  spi_link_if.dev                   spi,
  // slave address selection
  input  wire logic                 i_addr_from_pins,
  input  wire logic [3:0]           i_factory_code,
  input  wire logic                 i_addr_select_high_pin,
  input  wire logic                 i_addr_select_low_pin,
  output logic      [6:0]           o_i2c_slave_addr,
  // two-wire address byte check
  input  wire logic                 i_i2c_addr_valid,
  input  wire logic [7:0]           i_i2c_addr_byte,
  output logic                      o_i2c_ack,
  output logic                      o_i2c_read,
  // two-wire register address counter
  input  wire logic                 i_i2c_reg_load,
  input  wire logic                 i_i2c_reg_inc,
  input  wire logic [7:0]           i_i2c_reg_start,
  output logic      [7:0]           o_i2c_reg_addr,
  // register access
  output logic                      o_wr_valid,
  output logic      [7:0]           o_wr_addr,
  output logic      [15:0]          o_wr_data,
  output logic      [7:0]           o_rd_addr,
  input  wire logic [15:0]          i_rd_data
);
  import cfg_port_pkg::*;

  localparam int GW = $clog2(GAP_CYCLES + 1);

  function automatic logic [6:0] pick_addr(input logic pins, input logic hi,
                                           input logic lo, input logic [3:0] code);
    logic [6:0] a;
    a = {I2C_ADDR_HIGH, code};
    if (pins) begin
      a = {I2C_ADDR_HIGH, hi, 1'b0, lo, 1'b0};
    end
    return a;
  endfunction

  // pins from outside: sclk, ss_b, mosi, mode strap, high pin, low pin
  logic [5:0] meta_q;
  logic [5:0] sync_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // serial clock resets to its mode 0 idle level: no false edge after reset
      meta_q <= 6'h02;
      sync_q <= 6'h02;
    end else begin
      meta_q <= {i_addr_select_low_pin, i_addr_select_high_pin, i_addr_from_pins,
                 spi.mosi, spi.ss_b, spi.sclk};
      sync_q <= meta_q;
    end
  end

  logic sclk_s;
  logic ss_b_s;
  logic mosi_s;
  assign sclk_s = sync_q[0];
  assign ss_b_s = sync_q[1];
  assign mosi_s = sync_q[2];

  // address selection and two-wire side
  logic [6:0] slv_q, slv_d;
  logic       ack_q, ack_d;
  logic       rdb_q, rdb_d;
  logic [7:0] ireg_q, ireg_d;

  always_comb begin
    slv_d  = pick_addr(sync_q[3], sync_q[4], sync_q[5], i_factory_code);
    ack_d  = ack_q;
    rdb_d  = rdb_q;
    ireg_d = ireg_q;
    if (i_i2c_addr_valid) begin
      ack_d = (i_i2c_addr_byte[7:1] == slv_q);
      rdb_d = i_i2c_addr_byte[0];
    end
    if (i_i2c_reg_load) begin
      ireg_d = i_i2c_reg_start;
    end else if (i_i2c_reg_inc) begin
      ireg_d = ireg_q + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      slv_q  <= 7'h60;
      ack_q  <= 1'b0;
      rdb_q  <= 1'b0;
      ireg_q <= ADDR_RST;
    end else begin
      slv_q  <= slv_d;
      ack_q  <= ack_d;
      rdb_q  <= rdb_d;
      ireg_q <= ireg_d;
    end
  end

  assign o_i2c_slave_addr = slv_q;
  assign o_i2c_ack        = ack_q;
  assign o_i2c_read       = rdb_q;
  assign o_i2c_reg_addr   = ireg_q;

  // serial frame engine
  frame_state_t st_q, st_d;
  logic [3:0]   bit_q, bit_d;
  logic [15:0]  rx_q, rx_d;
  logic [15:0]  tx_q, tx_d;
  logic         miso_q, miso_d;
  logic         rd_q, rd_d;
  logic [7:0]   addr_q, addr_d;
  logic         wv_q, wv_d;
  logic [7:0]   wa_q, wa_d;
  logic [15:0]  wd_q, wd_d;
  logic [GW-1:0] gap_q, gap_d;
  logic         gok_q, gok_d;
  logic         sclk_p_q;
  logic         ss_p_q;

  logic rise;
  logic fall;
  logic sel;
  logic [15:0] word;

  assign sel  = ~ss_b_s;
  // modes 0 and 3 both sample on rising and launch on falling
  assign rise = sel & sclk_s & ~sclk_p_q;
  assign fall = sel & ~sclk_s & sclk_p_q;
  assign word = {rx_q[14:0], mosi_s};

  always_comb begin
    st_d   = st_q;
    bit_d  = bit_q;
    rx_d   = rx_q;
    tx_d   = tx_q;
    miso_d = miso_q;
    rd_d   = rd_q;
    addr_d = addr_q;
    wv_d   = 1'b0;
    wa_d   = wa_q;
    wd_d   = wd_q;
    gap_d  = gap_q;
    gok_d  = gok_q;
    if (ss_b_s) begin
      // measure idle time since the frame ended
      miso_d = 1'b0;
      if (!ss_p_q) begin
        gap_d = '0;
        gok_d = 1'b0;
      end else if (!gok_q) begin
        gap_d = gap_q + 1'b1;
        gok_d = (gap_q == GW'(GAP_CYCLES - 1));
      end
    end else if (ss_p_q) begin
      bit_d = 4'h0;
      if (gok_q || st_q == FR_CMD || st_q == FR_ADDR) begin
        st_d = FR_CMD;
      end else if (st_q == FR_DATA && rd_q) begin
        // short gap: keep streaming the next register
        miso_d = i_rd_data[15];
        tx_d   = {i_rd_data[14:0], 1'b0};
      end
    end else if (rise) begin
      rx_d  = word;
      bit_d = bit_q + 4'h1;
      unique case (st_q)
        FR_CMD: begin
          if (bit_q == 4'h7) begin
            bit_d = 4'h0;
            if (word[7:0] == CMD_WRITE) begin
              st_d = FR_ADDR;
              rd_d = 1'b0;
            end else if (word[7:0] == CMD_READ) begin
              st_d = FR_ADDR;
              rd_d = 1'b1;
            end else begin
              st_d = FR_SKIP;
            end
          end
        end
        FR_ADDR: begin
          if (bit_q == 4'h7) begin
            bit_d  = 4'h0;
            addr_d = word[7:0];
            st_d   = FR_DATA;
          end
        end
        FR_DATA: begin
          if (bit_q == 4'hF) begin
            if (!rd_q) begin
              wv_d = 1'b1;
              wa_d = addr_q;
              wd_d = word;
            end
            addr_d = addr_q + 8'h01;
          end
        end
        FR_SKIP: begin
          bit_d = 4'h0;
        end
      endcase
    end else if (fall && st_q == FR_DATA && rd_q) begin
      // only read frames launch data: link stays half duplex
      if (bit_q == 4'h0) begin
        miso_d = i_rd_data[15];
        tx_d   = {i_rd_data[14:0], 1'b0};
      end else begin
        miso_d = tx_q[15];
        tx_d   = {tx_q[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q     <= FR_CMD;
      bit_q    <= 4'h0;
      rx_q     <= WORD_RST;
      tx_q     <= WORD_RST;
      miso_q   <= 1'b0;
      rd_q     <= 1'b0;
      addr_q   <= ADDR_RST;
      wv_q     <= 1'b0;
      wa_q     <= ADDR_RST;
      wd_q     <= WORD_RST;
      gap_q    <= '0;
      gok_q    <= 1'b1;
      sclk_p_q <= 1'b0;
      ss_p_q   <= 1'b1;
    end else begin
      st_q     <= st_d;
      bit_q    <= bit_d;
      rx_q     <= rx_d;
      tx_q     <= tx_d;
      miso_q   <= miso_d;
      rd_q     <= rd_d;
      addr_q   <= addr_d;
      wv_q     <= wv_d;
      wa_q     <= wa_d;
      wd_q     <= wd_d;
      gap_q    <= gap_d;
      gok_q    <= gok_d;
      sclk_p_q <= sclk_s;
      ss_p_q   <= ss_b_s;
    end
  end

  assign spi.miso_out = miso_q;
  assign spi.miso_oe  = sel;
  assign o_wr_valid   = wv_q;
  assign o_wr_addr    = wa_q;
  assign o_wr_data    = wd_q;
  assign o_rd_addr    = addr_q;

endmodule
`default_nettype wire

// ==== rtl/cfg_port_host.sv ====
// host end: serial master issuing one-word command frames
`timescale 1ns/10ps
`default_nettype none
module cfg_port_host
  import cfg_port_pkg::*;
#(
  parameter int SCLK_HALF  = cfg_port_pkg::SCLK_HALF_DEF,
  parameter int GAP_CYCLES = cfg_port_pkg::GAP_CYCLES_DEF
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // serial link
  spi_link_if.host         spi,
  // request
  input  wire logic        i_req_valid,
  output logic             o_req_ready,
  input  wire logic        i_req_read,
  input  wire logic [7:0]  i_req_addr,
  input  wire logic [15:0] i_req_data,
  // response
  output logic             o_rsp_valid,
  output logic      [15:0] o_rsp_data
);
  import cfg_port_pkg::*;

  localparam int EDGE = SS_EDGE_HALVES * SCLK_HALF;
  localparam int CMAX = (GAP_CYCLES > EDGE) ? GAP_CYCLES : EDGE;
  localparam int CW   = $clog2(CMAX + 1);
  localparam int DW   = $clog2(SCLK_HALF + 1);

  logic miso_m_q;
  logic miso_s_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      miso_m_q <= 1'b0;
      miso_s_q <= 1'b0;
    end else begin
      miso_m_q <= spi.miso;
      miso_s_q <= miso_m_q;
    end
  end

  host_state_t st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [DW-1:0] div_q, div_d;
  logic [4:0]    bit_q, bit_d;
  logic [31:0]   sh_q, sh_d;
  logic [15:0]   rx_q, rx_d;
  logic          rd_q, rd_d;
  logic          sclk_q, sclk_d;
  logic          ss_b_q, ss_b_d;
  logic          mosi_q, mosi_d;
  logic          rv_q, rv_d;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    div_d  = div_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    rx_d   = rx_q;
    rd_d   = rd_q;
    sclk_d = sclk_q;
    ss_b_d = ss_b_q;
    mosi_d = mosi_q;
    rv_d   = 1'b0;
    unique case (st_q)
      HS_IDLE: begin
        if (i_req_valid) begin
          // every exchange starts here, one word per frame
          sh_d   = {(i_req_read ? CMD_READ : CMD_WRITE), i_req_addr, i_req_data};
          mosi_d = i_req_read ? CMD_READ[7] : CMD_WRITE[7];
          rd_d   = i_req_read;
          ss_b_d = 1'b0;
          cnt_d  = '0;
          st_d   = HS_LEAD;
        end
      end
      HS_LEAD: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CW'(EDGE - 1)) begin
          div_d = '0;
          bit_d = 5'h00;
          st_d  = HS_SHIFT;
        end
      end
      HS_SHIFT: begin
        // mode 0: idle low, sample on rise, launch on fall
        div_d = div_q + 1'b1;
        if (div_q == DW'(SCLK_HALF - 1)) begin
          div_d  = '0;
          sclk_d = ~sclk_q;
          if (!sclk_q) begin
            rx_d = {rx_q[14:0], miso_s_q};
          end else begin
            bit_d  = bit_q + 5'h01;
            sh_d   = {sh_q[30:0], 1'b0};
            mosi_d = sh_q[30];
            if (bit_q == 5'h1F) begin
              cnt_d = '0;
              st_d  = HS_TRAIL;
            end
          end
        end
      end
      HS_TRAIL: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CW'(EDGE - 1)) begin
          ss_b_d = 1'b1;
          mosi_d = 1'b0;
          rv_d   = rd_q;
          cnt_d  = '0;
          st_d   = HS_GAP;
        end
      end
      HS_GAP: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CW'(GAP_CYCLES - 1)) begin
          st_d = HS_IDLE;
        end
      end
      default: begin
        st_d = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q   <= HS_IDLE;
      cnt_q  <= '0;
      div_q  <= '0;
      bit_q  <= 5'h00;
      sh_q   <= 32'h0000_0000;
      rx_q   <= WORD_RST;
      rd_q   <= 1'b0;
      sclk_q <= 1'b0;
      ss_b_q <= 1'b1;
      mosi_q <= 1'b0;
      rv_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      div_q  <= div_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      rx_q   <= rx_d;
      rd_q   <= rd_d;
      sclk_q <= sclk_d;
      ss_b_q <= ss_b_d;
      mosi_q <= mosi_d;
      rv_q   <= rv_d;
    end
  end

  assign o_req_ready = (st_q == HS_IDLE);
  assign o_rsp_valid = rv_q;
  assign o_rsp_data  = rx_q;
  assign spi.sclk    = sclk_q;
  assign spi.ss_b    = ss_b_q;
  assign spi.mosi    = mosi_q;

endmodule
`default_nettype wire

// ==== sim/serial_config_port_chk.sv ====
// assertions on the serial link between the host end and the device end
`timescale 1ns/10ps
`default_nettype none
module serial_config_port_chk
  import cfg_port_pkg::*;
#(
  parameter int SCLK_HALF  = cfg_port_pkg::SCLK_HALF_DEF,
  parameter int GAP_CYCLES = cfg_port_pkg::GAP_CYCLES_DEF
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // link signals
  input wire logic sclk,
  input wire logic ss_b,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe
);
  logic       sclk_q;
  logic [7:0] bits_q;
  logic [7:0] high_q;
  int         gap_q;

  // gap counter starts full: the first frame after reset is legal
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_q <= 1'b0;
      bits_q <= 8'h00;
      high_q <= 8'h00;
      gap_q  <= GAP_CYCLES;
    end else begin
      sclk_q <= sclk;
      bits_q <= ss_b ? 8'h00 : bits_q + 8'((sclk && !sclk_q) ? 1 : 0);
      high_q <= sclk ? high_q + 8'h01 : 8'h00;
      gap_q  <= !ss_b ? 0 : ((gap_q < GAP_CYCLES) ? gap_q + 1 : gap_q);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_oe_off_idle: assert property (ss_b [*3] |-> !miso_oe)
    else $error("slave output driven while deselected");
  a_oe_on_sel: assert property ($fell(ss_b) |-> ##[1:6] miso_oe)
    else $error("slave output not enabled after select");
  a_miso_release: assert property ($rose(ss_b) |-> ##[1:6] (!miso_oe && !miso_out))
    else $error("slave output not released after deselect");
  a_sclk_idle: assert property (ss_b |-> !sclk)
    else $error("serial clock not idle low");
  a_sel_lead: assert property ($fell(ss_b) |-> (!sclk) [*8])
    else $error("serial clock too soon after select");
  a_mosi_hold: assert property ($rose(sclk) |-> ##1 ($stable(mosi)) [*7])
    else $error("master data moved while clock high");
  a_sclk_half: assert property ($fell(sclk) |-> high_q == 8'(SCLK_HALF))
    else $error("serial clock high time wrong");
  a_frame_bits: assert property ($rose(ss_b) |-> bits_q == 8'(CMD_BITS + ADDR_BITS + DATA_BITS))
    else $error("frame bit count wrong");
  a_gap_kept: assert property ($fell(ss_b) |-> gap_q >= GAP_CYCLES)
    else $error("frames closer than the gap");
endmodule
`default_nettype wire

// ==== sim/serial_config_port_tb_top.sv ====
// self-checking bench: host and device joined, plus a device on a bench-driven link
`timescale 1ns/10ps
`default_nettype none
module serial_config_port_tb_top;
  import cfg_port_pkg::*;
  localparam int GAP  = 20;
  localparam int HALF = 8;
  logic        i_clk;
  logic        i_rst_b;
  logic        req_valid;
  logic        req_read;
  logic [7:0]  req_addr;
  logic [15:0] req_data;
  logic        pins_mode;
  logic [3:0]  f_code;
  logic        hi_pin;
  logic        lo_pin;
  logic        a_valid;
  logic [7:0]  a_byte;
  logic        r_load;
  logic        r_inc;
  logic [7:0]  r_start;
  logic        req_ready;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic [6:0]  slave_addr;
  logic        ack;
  logic        rd_bit;
  logic [7:0]  reg_addr;
  logic        wr_valid;
  logic [7:0]  wr_addr;
  logic [15:0] wr_data;
  logic [7:0]  rd_addr;
  logic        wr_valid_b;
  logic [7:0]  wr_addr_b;
  logic [15:0] wr_data_b;
  logic [7:0]  rd_addr_b;
  logic [31:0] cap;
  int          ncap;
  logic        sclk_q;
  logic        ss_q;
  logic [23:0] wq[$];
  logic [23:0] exp_q[7];
  logic [6:0]  exp_a;
  int          fail_count = 0;
  int          n_checks = 0;

  spi_link_if link_a ();
  spi_link_if link_b ();

  cfg_port_host #(.SCLK_HALF(HALF), .GAP_CYCLES(GAP)) cfg_port_host_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .spi(link_a.host), .i_req_valid(req_valid),
    .o_req_ready(req_ready), .i_req_read(req_read), .i_req_addr(req_addr),
    .i_req_data(req_data), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data));
  cfg_port_dev #(.GAP_CYCLES(GAP)) cfg_port_dev_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .spi(link_a.dev), .i_addr_from_pins(pins_mode),
    .i_factory_code(f_code), .i_addr_select_high_pin(hi_pin),
    .i_addr_select_low_pin(lo_pin), .o_i2c_slave_addr(slave_addr),
    .i_i2c_addr_valid(a_valid), .i_i2c_addr_byte(a_byte), .o_i2c_ack(ack),
    .o_i2c_read(rd_bit), .i_i2c_reg_load(r_load), .i_i2c_reg_inc(r_inc),
    .i_i2c_reg_start(r_start), .o_i2c_reg_addr(reg_addr), .o_wr_valid(wr_valid),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_addr(rd_addr),
    .i_rd_data({~rd_addr, rd_addr}));
  // second device faces the bench, which can break the master's rules
  cfg_port_dev #(.GAP_CYCLES(GAP)) cfg_port_dev_fault_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .spi(link_b.dev), .i_addr_from_pins(pins_mode),
    .i_factory_code(f_code), .i_addr_select_high_pin(hi_pin),
    .i_addr_select_low_pin(lo_pin), .o_i2c_slave_addr(), .i_i2c_addr_valid(a_valid),
    .i_i2c_addr_byte(a_byte), .o_i2c_ack(), .o_i2c_read(), .i_i2c_reg_load(r_load),
    .i_i2c_reg_inc(r_inc), .i_i2c_reg_start(r_start), .o_i2c_reg_addr(),
    .o_wr_valid(wr_valid_b), .o_wr_addr(wr_addr_b), .o_wr_data(wr_data_b),
    .o_rd_addr(rd_addr_b), .i_rd_data({~rd_addr_b, rd_addr_b}));
  serial_config_port_chk #(.SCLK_HALF(HALF), .GAP_CYCLES(GAP)) serial_config_port_chk_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .sclk(link_a.sclk), .ss_b(link_a.ss_b),
    .mosi(link_a.mosi), .miso_out(link_a.miso_out), .miso_oe(link_a.miso_oe));

  // wire-level capture of the master's bits on the joined link
  always @(posedge i_clk) begin
    sclk_q <= link_a.sclk;
    ss_q   <= link_a.ss_b;
    if (!link_a.ss_b && ss_q) ncap <= 0;
    else if (!link_a.ss_b && link_a.sclk && !sclk_q) begin
      cap  <= {cap[30:0], link_a.mosi};
      ncap <= ncap + 1;
    end
  end

  always @(posedge i_clk) if (wr_valid_b) wq.push_back({wr_addr_b, wr_data_b});

  task automatic complete_run;
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_hi(ref logic s);
    int k;
    k = 0;
    while (s !== 1'b1) begin
      @(negedge i_clk);
      k++;
      if (k > 3000) begin
        fail_count++;
        $display("[ERR] %0t wait ran out", $time);
        complete_run();
      end
    end
  endtask

  task automatic host_op(input logic rd, input logic [7:0] a, input logic [15:0] d);
    wait_hi(req_ready);
    @(posedge i_clk);
    req_valid <= 1'b1;
    req_read  <= rd;
    req_addr  <= a;
    req_data  <= d;
    @(posedge i_clk);
    req_valid <= 1'b0;
    if (rd) begin
      wait_hi(rsp_valid);
      check(rsp_data, {~a, a});
    end else begin
      wait_hi(wr_valid);
      check({wr_addr, wr_data}, {a, d});
    end
    check(cap[31:16], {rd ? CMD_READ : CMD_WRITE, a});
    check(ncap, 32);
  endtask

  task automatic probe(input logic [7:0] b, input logic e);
    @(posedge i_clk);
    a_valid <= 1'b1;
    a_byte  <= b;
    @(posedge i_clk);
    a_valid <= 1'b0;
    repeat (2) @(negedge i_clk);
    check(ack, e);
    check(rd_bit, b[0]);
  endtask

  // mode 3 idles the clock high; sel low keeps the device deselected
  task automatic bb_frame(input logic m3, input logic sel, input int n, input logic [47:0] v);
    @(posedge i_clk);
    link_b.sclk <= m3;
    repeat (2) @(posedge i_clk);
    link_b.ss_b <= !sel;
    repeat (3 * HALF) @(posedge i_clk);
    for (int i = n - 1; i >= 0; i--) begin
      link_b.sclk <= 1'b0;
      link_b.mosi <= v[i];
      repeat (HALF) @(posedge i_clk);
      link_b.sclk <= 1'b1;
      repeat (HALF) @(posedge i_clk);
    end
    link_b.sclk <= m3;
    repeat (3 * HALF) @(posedge i_clk);
    link_b.ss_b <= 1'b1;
    link_b.mosi <= !link_b.mosi;
    @(posedge i_clk);
  endtask

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  initial begin
    {i_rst_b, req_valid, req_read, req_addr, req_data} = '0;
    {pins_mode, f_code, hi_pin, lo_pin, a_valid, a_byte} = '0;
    {r_load, r_inc, r_start} = '0;
    link_b.sclk = 1'b0;
    link_b.ss_b = 1'b1;
    link_b.mosi = 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      exp_a = (i < 16) ? {3'h6, 4'(i)} : {3'h6, i[1], 1'b0, i[0], 1'b0};
      @(posedge i_clk);
      pins_mode <= (i >= 16);
      f_code    <= (i < 16) ? 4'(i) : 4'hF;
      hi_pin    <= i[0];
      lo_pin    <= i[1];
      if (i >= 16) begin
        hi_pin <= i[1];
        lo_pin <= i[0];
      end
      repeat (6) @(negedge i_clk);
      if (i < 16) check(slave_addr, exp_a);
      else check(slave_addr, exp_a);
      probe({exp_a, i[0]}, 1'b1);
      probe({exp_a ^ 7'h01, 1'b0}, 1'b0);
    end
    @(posedge i_clk);
    r_load  <= 1'b1;
    r_start <= 8'hFE;
    @(posedge i_clk);
    r_load <= 1'b0;
    r_inc  <= 1'b1;
    @(negedge i_clk);
    @(negedge i_clk);
    check(reg_addr, 8'hFF);
    @(posedge i_clk);
    r_inc <= 1'b0;
    @(negedge i_clk);
    check(reg_addr, 8'h00);
    host_op(1'b0, 8'h21, 16'hBEEF);
    host_op(1'b1, 8'h21, 16'h0000);
    host_op(1'b1, 8'hFF, 16'h0000);
    host_op(1'b0, 8'h00, 16'h8001);
    bb_frame(1'b0, 1'b1, 48, {CMD_WRITE, 8'h10, 16'hABCD, 16'h1234});
    check(wq.size(), 2);
    repeat (5) @(posedge i_clk);
    bb_frame(1'b0, 1'b1, 32, {16'h0000, CMD_WRITE, 8'h40, 16'h5555});
    check(wq.size(), 4);
    repeat (GAP + 10) @(posedge i_clk);
    bb_frame(1'b1, 1'b1, 48, {CMD_WRITE, 8'hFF, 16'h1111, 16'h2222});
    check(wq.size(), 6);
    repeat (GAP + 10) @(posedge i_clk);
    bb_frame(1'b0, 1'b0, 32, {16'h0000, CMD_WRITE, 8'h50, 16'h6666});
    check(wq.size(), 6);
    repeat (GAP + 10) @(posedge i_clk);
    bb_frame(1'b0, 1'b1, 32, {16'h0000, 8'h55, 8'h20, 16'h7777});
    check(wq.size(), 6);
    repeat (GAP + 10) @(posedge i_clk);
    bb_frame(1'b0, 1'b1, 32, {16'h0000, CMD_WRITE, 8'h30, 16'h9999});
    check(wq.size(), 7);
    exp_q = '{24'h10ABCD, 24'h111234, 24'h120240, 24'h135555,
              24'hFF1111, 24'h002222, 24'h309999};
    foreach (exp_q[i]) check(wq[i], exp_q[i]);
    complete_run();
  end
endmodule
`default_nettype wire
